// ==== dv/tb.sv ====
// Self-checking bench for the EPROM host controller
`timescale 1ns/1ps
module tb;
  import uvep_pkg::*;
  logic        clk_sys;
  logic        rst;
  logic        reqValid;
  logic        reqReady;
  logic        rspValid;
  logic        oe;
  uvep_req_t   req;
  uvep_ctl_t   ctl;
  logic [12:0] addrOut;
  logic [7:0]  rspData;
  logic [7:0]  dOut;
  logic [7:0]  devQ;
  int          fails;
  int          compares;
  uvep_host uvep_host_i (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .rspValid(rspValid), .rspData(rspData), .ctl(ctl),
    .addrOut(addrOut), .dataIoLinesIn(oe ? dOut : devQ), .dataIoLinesOut(dOut),
    .dataIoLinesOe(oe));
  uvep_eprom_model uvep_eprom_model_i (.ctl(ctl), .addr(addrOut), .din(dOut), .q(devQ));
  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_reset;
    rst = 1'h1;
    repeat (20) @(negedge clk_sys);
    check({17'h0, ctl, oe, reqReady, rspValid}, {17'h0, 4'he, 3'h2});
    rst = 1'h0;
  endtask
  task automatic rd(input logic [12:0] a);
    int n;
    @(negedge clk_sys);
    reqValid = 1'h1;
    req = '{write: 1'h0, addr: a, data: 8'h00};
    @(negedge clk_sys);
    reqValid = 1'h0;
    n = 1;
    while (rspValid !== 1'h1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check(n[23:0], 24'h16);
    check({16'h0, rspData}, {16'h0, ~a[7:0]});
  endtask
  task automatic test_reads;
    rd(13'h0000);
    rd(13'h1fff);
    rd(13'h0a5a);
    $display("reads back to back done");
  endtask
  task automatic test_write_abort;
    @(negedge clk_sys);
    reqValid = 1'h1;
    req = '{write: 1'h1, addr: 13'h0a5a, data: 8'h3c};
    @(negedge clk_sys);
    check({18'h0, ctl, oe, reqReady}, {18'h0, 4'h9, 2'h2});
    check({3'h0, addrOut, dOut}, 24'h0a5a3c);
    repeat (79) @(negedge clk_sys);
    check({23'h0, ctl.powerDownProgramStrobe}, 24'h1);
    repeat (1000) @(negedge clk_sys);
    check({6'h0, ctl, reqReady, addrOut}, {6'h0, 4'h1, 1'h0, 13'h0a5a});
    reqValid = 1'h0;
    do_reset;
    rd(13'h0a5a);
    $display("write aborted by reset done");
  endtask
  initial begin
    #200000;
    fails++;
    test_done;
  end
  initial begin
    rst = 1'h1;
    reqValid = 1'h0;
    req = '0;
    do_reset;
    test_reads;
    test_write_abort;
    test_done;
  end
endmodule
bind uvep_host uvep_chk uvep_chk_i (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid),
  .reqReady(reqReady), .req(req), .rspValid(rspValid), .ctl(ctl), .addrOut(addrOut),
  .dataIoLinesOut(dataIoLinesOut), .dataIoLinesOe(dataIoLinesOe));

// ==== dv/uvep_chk_assertions.sv ====
// Port checks for the EPROM host controller
`timescale 1ns/1ps
module uvep_chk
  import uvep_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        reqValid,
  input wire logic        reqReady,
  input wire uvep_req_t   req,
  input wire logic        rspValid,
  input wire uvep_ctl_t   ctl,
  input wire logic [12:0] addrOut,
  input wire logic [7:0]  dataIoLinesOut,
  input wire logic        dataIoLinesOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [21:0] lowCnt_r;
  logic [21:0] lowCnt_nxt;
  logic        tkRd;
  logic        tkWr;
  logic        pulse;
  assign tkRd = reqValid && reqReady && !req.write;
  assign tkWr = reqValid && reqReady && req.write;
  assign pulse = ctl.progSupplyHigh && !ctl.powerDownProgramStrobe;
  // Counts only while the pulse is applied to a powered device
  always_comb lowCnt_nxt = pulse ? lowCnt_r + 22'h1 : 22'h0;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      lowCnt_r <= 22'h0;
    else
      lowCnt_r <= lowCnt_nxt;
  rd_select_a:
    assert property (tkRd |=> !ctl.powerDownProgramStrobe && !ctl.firstSelectLow
      && !ctl.secondSelectLow && !ctl.progSupplyHigh) else $error("read select");
  rd_answer_a:
    assert property (tkRd |=> !rspValid [*8] ##1 !rspValid [*8] ##1 !rspValid [*5] ##1 rspValid)
      else $error("read latency");
  rd_release_a:
    assert property (tkRd |-> ##22 ctl.powerDownProgramStrobe && ctl.firstSelectLow
      && ctl.secondSelectLow) else $error("read not released");
  wr_enter_a:
    assert property (tkWr |=> ctl.progSupplyHigh && dataIoLinesOe && ctl.powerDownProgramStrobe
      && !ctl.firstSelectLow && !ctl.secondSelectLow) else $error("program entry");
  wr_setup_a:
    assert property (tkWr |-> ##80 ctl.powerDownProgramStrobe ##1 !ctl.powerDownProgramStrobe)
      else $error("setup time");
  io_float_a:
    assert property (!ctl.progSupplyHigh |-> !dataIoLinesOe) else $error("bus driven in read");
  pulse_hold_a:
    assert property (pulse |=> ctl.progSupplyHigh && $stable(addrOut)
      && $stable(dataIoLinesOut)) else $error("moved in pulse");
  pulse_max_a:
    assert property (lowCnt_r <= 22'h2191c0) else $error("pulse too long");
  pulse_min_a:
    assert property ($rose(ctl.powerDownProgramStrobe) && ctl.progSupplyHigh
      |-> lowCnt_r >= 22'h1b7740) else $error("pulse too short");
endmodule

// ==== dv/uvep_eprom_model.sv ====
// Behavioural 8K x 8 EPROM facing the host controller
`timescale 1ns/1ps
module uvep_eprom_model
  import uvep_pkg::*;
(
  input  wire uvep_ctl_t   ctl,
  input  wire logic [12:0] addr,
  input  wire logic [7:0]  din,
  output      logic [7:0]  q
);
  logic [7:0] mem [0:8191];
  logic       rdEn;
  // Each word differs from its neighbours so a wrong address shows
  initial for (int i = 0; i < 8192; i++) mem[i] = ~i[7:0];
  assign rdEn = !ctl.powerDownProgramStrobe && !ctl.firstSelectLow
    && !ctl.secondSelectLow && !ctl.progSupplyHigh;
  // Floating bus shows the complement so stale data never passes
  assign #450 q = rdEn ? mem[addr] : ~mem[addr];
  always @(posedge ctl.powerDownProgramStrobe)
    if (ctl.progSupplyHigh && !ctl.firstSelectLow && !ctl.secondSelectLow)
      mem[addr] = mem[addr] & din;
endmodule

// ==== inc/uvep_defs.svh ====
// Timing and width constants for the EPROM programmer controller
`ifndef UVEP_DEFS_SVH
`define UVEP_DEFS_SVH
`define UVEP_ADDR_W        13
`define UVEP_DATA_W        8
`define UVEP_CLK_PS        25000
`define UVEP_ACCESS_NS     450
`define UVEP_SETUP_NS      2000
`define UVEP_HOLD_NS       2000
`define UVEP_PULSE_US      50000
// Access wait: the part's delay, one edge of margin and two synchroniser stages
`define UVEP_ACCESS_CYC    ((`UVEP_ACCESS_NS * 1000 + `UVEP_CLK_PS - 1) / `UVEP_CLK_PS + 3)
`define UVEP_SETUP_CYC     ((`UVEP_SETUP_NS * 1000 + `UVEP_CLK_PS - 1) / `UVEP_CLK_PS)
`define UVEP_HOLD_CYC      ((`UVEP_HOLD_NS * 1000 + `UVEP_CLK_PS - 1) / `UVEP_CLK_PS)
`define UVEP_PULSE_CYC     ((`UVEP_PULSE_US * 1000) / (`UVEP_CLK_PS / 1000))
`define UVEP_PULSE_MAX_US  55000
`define UVEP_GUARD_MARGIN  2
`define UVEP_PULSE_MAX_CYC ((`UVEP_PULSE_MAX_US * 1000) / (`UVEP_CLK_PS / 1000))
`define UVEP_GUARD_W       22
`define UVEP_CNT_W         21
`endif

// ==== inc/uvep_pkg.sv ====
// Types shared by the EPROM programmer controller
package uvep_pkg;
  `include "uvep_defs.svh"
  typedef struct packed {
    logic                      write;
    logic [`UVEP_ADDR_W-1:0]   addr;
    logic [`UVEP_DATA_W-1:0]   data;
  } uvep_req_t;
  typedef struct packed {
    logic                      powerDownProgramStrobe;
    logic                      firstSelectLow;
    logic                      secondSelectLow;
    logic                      progSupplyHigh;
  } uvep_ctl_t;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RDLY  = 6'h02,
    ST_SETUP = 6'h04,
    ST_PULSE = 6'h08,
    ST_HOLD  = 6'h10,
    ST_DONE  = 6'h20
  } uvep_state_t;
endpackage

// ==== verilog/uvep_host.sv ====
// Host controller that reads and programs an 8K x 8 UV EPROM
`timescale 1ns/1ps
module uvep_host
  import uvep_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     reqValid,
  output      logic                     reqReady,
  input  wire uvep_req_t                req,
  output      logic                     rspValid,
  output      logic [`UVEP_DATA_W-1:0]  rspData,
  output      uvep_ctl_t                ctl,
  output      logic [`UVEP_ADDR_W-1:0]  addrOut,
  input  wire logic [`UVEP_DATA_W-1:0]  dataIoLinesIn,
  output      logic [`UVEP_DATA_W-1:0]  dataIoLinesOut,
  output      logic                     dataIoLinesOe
);
  // One operation at a time: a read keeps the part selected for the access
  // time plus synchroniser latency; a program cycle raises the supply,
  // pulses the strobe once and drops the supply before the next request
  localparam logic [`UVEP_CNT_W-1:0] ACC_C   = `UVEP_CNT_W'(`UVEP_ACCESS_CYC);
  localparam logic [`UVEP_CNT_W-1:0] SETUP_C = `UVEP_CNT_W'(`UVEP_SETUP_CYC);
  localparam logic [`UVEP_CNT_W-1:0] HOLD_C  = `UVEP_CNT_W'(`UVEP_HOLD_CYC);
  localparam logic [`UVEP_CNT_W-1:0] PULSE_C = `UVEP_CNT_W'(`UVEP_PULSE_CYC);
  localparam logic [`UVEP_GUARD_W-1:0] GUARD_C =
    `UVEP_GUARD_W'(`UVEP_PULSE_MAX_CYC - `UVEP_GUARD_MARGIN);

  // Standby: strobe and both selects high, supply at read level, so the
  // part floats its outputs and draws standby current
  localparam uvep_ctl_t IDLE_CTL = '{
    powerDownProgramStrobe: 1'h1,
    firstSelectLow:         1'h1,
    secondSelectLow:        1'h1,
    progSupplyHigh:         1'h0
  };

  // Read: every control low with the supply left at the read level
  localparam uvep_ctl_t READ_CTL = '{
    powerDownProgramStrobe: 1'h0,
    firstSelectLow:         1'h0,
    secondSelectLow:        1'h0,
    progSupplyHigh:         1'h0
  };

  uvep_state_t              state_r, state_nxt;
  logic [`UVEP_CNT_W-1:0]   cnt_r, cnt_nxt;
  uvep_req_t                cur_r, cur_nxt;
  uvep_ctl_t                ctl_r, ctl_nxt;
  logic                     oe_r, oe_nxt;
  logic                     rv_r, rv_nxt;
  logic [`UVEP_DATA_W-1:0]  rd_r, rd_nxt;
  logic [`UVEP_DATA_W-1:0]  sync1_r, sync2_r;
  logic [`UVEP_DATA_W-1:0]  sync1_nxt, sync2_nxt;
  logic [`UVEP_GUARD_W-1:0] guard_r, guard_nxt;
  logic                     guardTrip;
  logic                     capRead;
  logic                     opDone;

  function automatic logic expired(input logic [`UVEP_CNT_W-1:0] c);
    expired = (c == `UVEP_CNT_W'(1));
  endfunction

  // Idle state parks the part in standby with supply at read level
  function automatic uvep_ctl_t idleCtl();
    idleCtl = IDLE_CTL;
  endfunction

  // Program mode: supply raised, both selects low, strobe as given
  function automatic uvep_ctl_t progCtl(input logic strobe);
    progCtl = '{powerDownProgramStrobe: strobe,
                firstSelectLow:         1'h0,
                secondSelectLow:        1'h0,
                progSupplyHigh:         1'h1};
  endfunction

  assign reqReady       = (state_r == ST_IDLE);
  assign rspValid       = rv_r;
  assign rspData        = rd_r;
  assign ctl            = ctl_r;
  assign addrOut        = cur_r.addr;
  assign dataIoLinesOut = cur_r.data;
  assign dataIoLinesOe  = oe_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    cur_nxt   = cur_r;
    ctl_nxt   = ctl_r;
    oe_nxt    = oe_r;
    capRead   = 1'h0;
    opDone    = 1'h0;
    case (state_r)
      ST_IDLE: begin
        if (reqValid) begin
          cur_nxt = req;
          cnt_nxt = req.write ? SETUP_C : ACC_C;
          if (req.write) begin
            // Supply raised and selects low before strobe falls
            ctl_nxt   = progCtl(1'h1);
            oe_nxt    = 1'b1;
            state_nxt = ST_SETUP;
          end else begin
            ctl_nxt   = READ_CTL;
            oe_nxt    = 1'b0;
            state_nxt = ST_RDLY;
          end
        end
      end
      ST_RDLY: begin
        // Capture only once the word has crossed both synchroniser stages;
        // the read answers later than the part needs, traded for safe sampling
        if (expired(cnt_r)) begin
          capRead   = 1'h1;
          ctl_nxt   = idleCtl();
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - `UVEP_CNT_W'(1);
        end
      end
      ST_SETUP: begin
        if (expired(cnt_r)) begin
          ctl_nxt   = progCtl(1'h0);
          cnt_nxt   = PULSE_C;
          state_nxt = ST_PULSE;
        end else begin
          cnt_nxt = cnt_r - `UVEP_CNT_W'(1);
        end
      end
      ST_PULSE: begin
        // The guard ends the pulse only if the count were ever too long
        if (expired(cnt_r) || guardTrip) begin
          ctl_nxt   = progCtl(1'h1);
          cnt_nxt   = HOLD_C;
          state_nxt = ST_HOLD;
        end else begin
          cnt_nxt = cnt_r - `UVEP_CNT_W'(1);
        end
      end
      ST_HOLD: begin
        // Address and data stay put until hold time has passed
        if (expired(cnt_r)) begin
          oe_nxt    = 1'b0;
          ctl_nxt   = idleCtl();
          opDone    = 1'h1;
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - `UVEP_CNT_W'(1);
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        ctl_nxt   = idleCtl();
        oe_nxt    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      cur_r   <= '0;
      ctl_r   <= IDLE_CTL;
      oe_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cur_r   <= cur_nxt;
      ctl_r   <= ctl_nxt;
      oe_r    <= oe_nxt;
    end
  end

  // Read data holds until the next read; rspValid pulses for one cycle
  always_comb begin
    rv_nxt = capRead || opDone;
    rd_nxt = capRead ? sync2_r : rd_r;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rv_r <= 1'h0;
      rd_r <= '0;
    end else begin
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Pins change with no relation to clk_sys, so only sync2_r feeds logic
  always_comb begin
    sync1_nxt = dataIoLinesIn;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // Backstop on the absolute strobe limit, independent of the pulse count;
  // a second counter is the price of surviving a wrong pulse constant
  always_comb begin
    guardTrip = (guard_r >= GUARD_C);
    if (ctl_r.progSupplyHigh && !ctl_r.powerDownProgramStrobe) begin
      guard_nxt = guard_r + `UVEP_GUARD_W'(1);
    end else begin
      guard_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      guard_r <= '0;
    end else begin
      guard_r <= guard_nxt;
    end
  end
endmodule
